// >>> verilog/fdm_pkg.sv
// Summary of operation
// RULE1 - read-start copies the addressed array byte into the byte register, no wait
// RULE2 - byte register keeps a read value until the next read or a write to it
// RULE3 - the core is not held while a read runs; it continues with the next access
// RULE4 - array holds 64 bytes in eight rows of eight; row erase, byte write
// RULE5 - software erases by loading location, then row-clear, unlock and launch bits
// RULE6 - row-clear self-clears unless unlock is set by the very next access
// RULE7 - unlock self-clears unless launch is set by the very next access
// RULE8 - the core is held for the whole erase cycle, then continues
// RULE9 - erase clears the row named by location bits five down to three
// RULE10 - byte write: location, byte, unlock, launch; core held for the cycle
// RULE11 - row-clear set by control writes or single-bit sets; unlock and launch only by single-bit sets
// RULE12 - a read starts only through a single-bit set of the read-start bit
// RULE13 - the access right after a start is taken normally, no padding needed
// RULE14 - row-clear makes the cycle erase only; cleared when the erase ends
// RULE15 - abort flag set when device reset cuts a cycle, cleared on success
// RULE16 - with unlock at zero no erase or write cycle can start
// RULE17 - launch bit starts a cycle and returns to zero when it ends
// RULE18 - read-start is control bit zero; bits seven to five read zero
// RULE19 - location holds six bits; bits seven and six read zero
// RULE20 - byte register is a full eight-bit read/write register
// RULE21 - software saves a row to RAM, erases it and writes the bytes back
// RULE22 - a busy counter times erase and write; core held, launch set until it ends
`default_nettype none
package fdm_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_BYTE = 8'h00;
    localparam logic [7:0] OFS_LOCATION = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_BITSET = 8'h0c;

    // control register bit positions
    localparam int unsigned BIT_READ = 0;
    localparam int unsigned BIT_LAUNCH = 1;
    localparam int unsigned BIT_UNLOCK = 2;
    localparam int unsigned BIT_ABORT = 3;
    localparam int unsigned BIT_FREE = 4;

    // array geometry
    localparam int unsigned ARRAY_BYTES = 64;
    localparam int unsigned ROW_HI = 5;
    localparam int unsigned ROW_LO = 3;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [5:0] LOCATION_RESET = 6'h00;

    // erase / write cycle time
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned NVM_CYCLE_NS = 2000;
    localparam logic [7:0] BUSY_CYCLES = 8'((NVM_CYCLE_NS * CLK_MHZ + 999) / 1000);

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } fdm_state_e;

    typedef struct packed {
        logic row_clear;
        logic abort_flag;
        logic array_unlock;
        logic cycle_launch;
    } fdm_ctrl_s;

    typedef struct packed {
        logic erase;
        logic write;
        logic [5:0] location;
        logic [7:0] data;
    } fdm_cmd_s;

endpackage
`default_nettype wire

// >>> verilog/fdm_array.sv
`timescale 1ns/1ns
`default_nettype none
module fdm_array (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // erase or write command, one cycle
    input wire fdm_pkg::fdm_cmd_s cmd,
    // read port
    input wire logic [5:0] rd_location,
    output logic [7:0] rd_byte
);

    logic [7:0] mem_reg [0:fdm_pkg::ARRAY_BYTES-1];

    // storage; reset only models a blank part at power-up
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < fdm_pkg::ARRAY_BYTES; i++) begin
                mem_reg[i] <= fdm_pkg::ERASED_BYTE;
            end
        end else if (cmd.erase) begin
            for (int i = 0; i < fdm_pkg::ARRAY_BYTES; i++) begin
                if (3'(i >> 3) == cmd.location[fdm_pkg::ROW_HI:fdm_pkg::ROW_LO]) begin
                    mem_reg[i] <= fdm_pkg::ERASED_BYTE; // [RULE4] [RULE9]
                end
            end
        end else if (cmd.write) begin
            mem_reg[cmd.location] <= cmd.data; // [RULE4]
        end
    end

    // combinational read so a read-start costs no wait
    assign rd_byte = mem_reg[rd_location];

endmodule
`default_nettype wire

// >>> verilog/fdm_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module fdm_ctrl (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // device reset that may cut a running cycle
    input wire logic dev_reset,
    // core hold while a cycle runs
    output logic core_stall,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    // axi4-lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    fdm_pkg::fdm_state_e state_reg;
    fdm_pkg::fdm_ctrl_s ctrl_reg;
    fdm_pkg::fdm_cmd_s cmd_reg;
    logic aw_have_reg, w_have_reg, awready_reg, wready_reg, wstrb0_reg;
    logic [7:0] addr_reg, wdata_reg, byte_reg, busy_cnt_reg, rd_byte, rd_value, stall_len_reg;
    logic bvalid_reg, arready_reg, rvalid_reg, stall_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [5:0] location_reg;
    logic free_armed_reg, unlock_armed_reg;
    logic aw_take, w_take, aw_have_next, w_have_next;
    logic do_write, do_read, access, hit, onehot;
    logic is_bitset, plain_ctrl, set_read, set_free, set_unlock, set_launch;
    logic launch_ok, cycle_end, cycle_abort, free_set_evt;

    ////////////////////////////////////////////////////////////////////////////
    // bus handshakes and access decode

    assign aw_take = s_axi_awvalid && awready_reg;
    assign w_take = s_axi_wvalid && wready_reg;
    assign do_read = s_axi_arvalid && arready_reg;
    // a read in the same cycle wins; the write goes next cycle
    assign do_write = aw_have_reg && w_have_reg && !bvalid_reg
                      && (state_reg == fdm_pkg::ST_IDLE) && !do_read;
    assign access = do_write || do_read;
    assign aw_have_next = aw_take || (aw_have_reg && !do_write);
    assign w_have_next = w_take || (w_have_reg && !do_write);
    assign hit = (addr_reg[7:4] == 4'h0) && (addr_reg[1:0] == 2'h0);
    assign onehot = (wdata_reg != 8'h00) && ((wdata_reg & (wdata_reg - 8'h01)) == 8'h00);

    // single-bit set access only counts with exactly one bit written
    assign is_bitset = do_write && wstrb0_reg && (addr_reg == fdm_pkg::OFS_BITSET)
                       && onehot; // [RULE11] [RULE12]
    assign plain_ctrl = do_write && wstrb0_reg && (addr_reg == fdm_pkg::OFS_CONTROL);
    assign set_read = is_bitset && wdata_reg[fdm_pkg::BIT_READ]; // [RULE12]
    assign set_launch = is_bitset && wdata_reg[fdm_pkg::BIT_LAUNCH];
    assign set_unlock = is_bitset && wdata_reg[fdm_pkg::BIT_UNLOCK];
    assign set_free = is_bitset && wdata_reg[fdm_pkg::BIT_FREE];
    assign free_set_evt = set_free || (plain_ctrl && wdata_reg[fdm_pkg::BIT_FREE]); // [RULE11]
    // launch only counts straight after the unlock set, with unlock still on
    assign launch_ok = set_launch && ctrl_reg.array_unlock
                       && unlock_armed_reg; // [RULE11] [RULE16]
    assign cycle_abort = (state_reg == fdm_pkg::ST_BUSY) && dev_reset;
    assign cycle_end = (state_reg == fdm_pkg::ST_BUSY) && !dev_reset
                       && (busy_cnt_reg == 8'h00);

    ////////////////////////////////////////////////////////////////////////////
    // write address and data capture, either order

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            addr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            awready_reg <= !aw_have_next;
            wready_reg <= !w_have_next;
            if (aw_take) begin
                addr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_reg <= s_axi_wdata[7:0];
                wstrb0_reg <= s_axi_wstrb[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write response; a launch holds it back for the whole cycle

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= fdm_pkg::RESP_OKAY;
        end else if (do_write && !launch_ok) begin
            bvalid_reg <= 1'b1; // [RULE13]
            bresp_reg <= hit ? fdm_pkg::RESP_OKAY : fdm_pkg::RESP_SLVERR;
        end else if (cycle_end || cycle_abort) begin
            bvalid_reg <= 1'b1; // [RULE8] [RULE10]
            bresp_reg <= fdm_pkg::RESP_OKAY;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel; reads wait while a cycle runs

    always_comb begin
        rd_value = 8'h00;
        case (s_axi_araddr)
            fdm_pkg::OFS_BYTE: rd_value = byte_reg; // [RULE20]
            fdm_pkg::OFS_LOCATION: rd_value = {2'b00, location_reg}; // [RULE19]
            fdm_pkg::OFS_CONTROL, fdm_pkg::OFS_BITSET: rd_value = {3'b000, ctrl_reg, 1'b0}; // [RULE18]
            default: rd_value = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= fdm_pkg::RESP_OKAY;
        end else begin
            arready_reg <= !arready_reg && !rvalid_reg && !launch_ok
                           && (state_reg == fdm_pkg::ST_IDLE);
            if (do_read) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= {24'h000000, rd_value};
                rresp_reg <= (s_axi_araddr[7:4] == 4'h0 && s_axi_araddr[1:0] == 2'h0)
                             ? fdm_pkg::RESP_OKAY : fdm_pkg::RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // byte and location registers

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            byte_reg <= fdm_pkg::BYTE_RESET;
        end else if (set_read) begin
            byte_reg <= rd_byte; // [RULE1] [RULE3]
        end else if (do_write && wstrb0_reg && addr_reg == fdm_pkg::OFS_BYTE) begin
            byte_reg <= wdata_reg; // [RULE2] [RULE20]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            location_reg <= fdm_pkg::LOCATION_RESET;
        end else if (do_write && wstrb0_reg && addr_reg == fdm_pkg::OFS_LOCATION) begin
            location_reg <= wdata_reg[5:0]; // [RULE19]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // unlock sequence tracking: only the very next access may continue it

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            free_armed_reg <= 1'b0;
            unlock_armed_reg <= 1'b0;
        end else if (access) begin
            free_armed_reg <= free_set_evt; // [RULE6]
            unlock_armed_reg <= set_unlock; // [RULE7]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control bits; hardware sets come last so they win

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= '0;
        end else begin
            if (plain_ctrl) begin
                // plain writes may clear unlock but never set it or launch
                ctrl_reg.row_clear <= wdata_reg[fdm_pkg::BIT_FREE];
                ctrl_reg.abort_flag <= wdata_reg[fdm_pkg::BIT_ABORT];
                ctrl_reg.array_unlock <= ctrl_reg.array_unlock
                                         && wdata_reg[fdm_pkg::BIT_UNLOCK]; // [RULE11]
            end
            if (set_free) begin
                ctrl_reg.row_clear <= 1'b1; // [RULE11]
            end
            if (is_bitset && wdata_reg[fdm_pkg::BIT_ABORT]) begin
                ctrl_reg.abort_flag <= 1'b1;
            end
            if (free_armed_reg && access && !set_unlock) begin
                ctrl_reg.row_clear <= 1'b0; // [RULE6]
            end
            if (set_unlock) begin
                ctrl_reg.array_unlock <= 1'b1; // [RULE11]
            end
            if (unlock_armed_reg && access && !set_launch) begin
                ctrl_reg.array_unlock <= 1'b0; // [RULE7]
            end
            if (launch_ok) begin
                ctrl_reg.cycle_launch <= 1'b1; // [RULE17]
            end
            if (cycle_end) begin
                ctrl_reg.cycle_launch <= 1'b0; // [RULE17]
                ctrl_reg.row_clear <= 1'b0; // [RULE14]
                ctrl_reg.abort_flag <= 1'b0; // [RULE15]
            end
            if (cycle_abort) begin
                ctrl_reg.cycle_launch <= 1'b0;
                ctrl_reg.row_clear <= 1'b0;
                ctrl_reg.array_unlock <= 1'b0;
                ctrl_reg.abort_flag <= 1'b1; // [RULE15]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cycle sequencer and busy counter

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= fdm_pkg::ST_IDLE;
            busy_cnt_reg <= 8'h00;
            stall_reg <= 1'b0;
        end else begin
            case (state_reg)
                fdm_pkg::ST_IDLE: begin
                    if (launch_ok) begin
                        state_reg <= fdm_pkg::ST_BUSY;
                        busy_cnt_reg <= fdm_pkg::BUSY_CYCLES - 8'h01; // [RULE22]
                        stall_reg <= 1'b1; // [RULE8] [RULE10]
                    end
                end
                fdm_pkg::ST_BUSY: begin
                    if (cycle_end || cycle_abort) begin
                        state_reg <= fdm_pkg::ST_IDLE;
                        stall_reg <= 1'b0;
                    end else begin
                        busy_cnt_reg <= busy_cnt_reg - 8'h01; // [RULE22]
                    end
                end
                default: begin
                    state_reg <= fdm_pkg::ST_IDLE;
                    stall_reg <= 1'b0;
                end
            endcase
        end
    end

    // array command lands at the end of the cycle, never on an abort
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_reg <= '0;
        end else begin
            cmd_reg.erase <= cycle_end && ctrl_reg.row_clear; // [RULE14] [RULE9]
            cmd_reg.write <= cycle_end && !ctrl_reg.row_clear; // [RULE10] [RULE14]
            cmd_reg.location <= location_reg;
            cmd_reg.data <= byte_reg;
        end
    end

    fdm_array u_array (
        .aclk(aclk),
        .aresetn(aresetn),
        .cmd(cmd_reg),
        .rd_location(location_reg),
        .rd_byte(rd_byte)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign core_stall = stall_reg;
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // helper: length of the current stall
    always_ff @(posedge aclk) begin
        if (!aresetn || !stall_reg) begin
            stall_len_reg <= 8'h00;
        end else begin
            stall_len_reg <= stall_len_reg + 8'h01;
        end
    end

    a_read_fetch: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
        set_read |=> (byte_reg == $past(rd_byte)) && bvalid_reg)
        else $error("read-start did not load the byte register");

    a_byte_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
        !set_read && !(do_write && addr_reg == fdm_pkg::OFS_BYTE) |=> $stable(byte_reg))
        else $error("byte register changed without cause");

    a_read_no_stall: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE3]
        set_read |-> !stall_reg ##1 !stall_reg)
        else $error("read held the core");

    a_free_autoclr: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE6]
        free_armed_reg && access && !set_unlock |=> !ctrl_reg.row_clear)
        else $error("row-clear not dropped after broken sequence");

    a_unlock_autoclr: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE7]
        unlock_armed_reg && access && !set_launch |=> !ctrl_reg.array_unlock)
        else $error("unlock not dropped after broken sequence");

    a_unlock_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE16]
        set_launch && !ctrl_reg.array_unlock |=> !stall_reg && !ctrl_reg.cycle_launch)
        else $error("cycle started while locked");

    a_stall_length: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE22]
        $fell(stall_reg) && !$past(dev_reset) |-> stall_len_reg == fdm_pkg::BUSY_CYCLES)
        else $error("cycle length differs from busy count");

    a_launch_busy: assert property (@(posedge aclk) disable iff (!aresetn || dev_reset) // [RULE17]
        launch_ok |=> (ctrl_reg.cycle_launch && stall_reg) [*8])
        else $error("launch bit or stall dropped early");

    a_erase_done: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE14]
        cycle_end && ctrl_reg.row_clear |=> cmd_reg.erase && !cmd_reg.write
        && !ctrl_reg.row_clear && !ctrl_reg.cycle_launch)
        else $error("erase did not finish cleanly");

    a_abort_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE15]
        cycle_abort |=> ctrl_reg.abort_flag && !cmd_reg.write && !cmd_reg.erase
        && !stall_reg)
        else $error("cut cycle not flagged");

    a_erase_row: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE9]
        cmd_reg.erase |-> cmd_reg.location[5:3] == location_reg[5:3])
        else $error("erase row differs from location");

endmodule
`default_nettype wire

// >>> tb/fdm_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// stands in for the processor core: one bench request becomes one bus transfer
module fdm_core_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // request from the bench
    input wire logic go,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] data,
    output logic done,
    output logic [31:0] rdata,
    output logic [1:0] resp,
    // axi4-lite master side
    output logic awvalid,
    input wire logic awready,
    output logic [7:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    output logic arvalid,
    input wire logic arready,
    output logic [7:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] s_rdata,
    input wire logic [1:0] rresp
);
    // payload held until its own ready, then scrambled so stale values never help
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {awvalid, wvalid, arvalid, bready, rready, done} <= '0;
            {awaddr, araddr, wdata, rdata, resp} <= '0;
        end else begin
            done <= 1'b0;
            bready <= 1'b1;
            rready <= 1'b1;
            if (go && we) begin // bench orders every write, single-bit sets included
                awvalid <= 1'b1;
                wvalid <= 1'b1;
                awaddr <= addr;
                wdata <= {24'h0, data};
            end
            if (go && !we) begin // a bus read starts on any bench request with we low
                arvalid <= 1'b1;
                araddr <= addr;
            end
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~awaddr;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~araddr;
            end
            if (bvalid && bready) begin
                done <= 1'b1;
                resp <= bresp;
            end
            if (rvalid && rready) begin
                done <= 1'b1;
                resp <= rresp;
                rdata <= s_rdata;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/flash_data_memory_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module flash_data_memory_control_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic dev_reset = 1'b0;
    logic go = 1'b0;
    logic we = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] data = 8'h00;
    logic done, core_stall, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr, d;
    logic [5:0] loc;
    logic [31:0] wdata, rdata, s_rdata;
    logic [1:0] resp, bresp, rresp;
    logic [7:0] mem [64];
    int fail_count = 0;
    int n_checks = 0;
    int stall_n = 0;

    always #10 aclk = ~aclk;
    // stall length, sampled before the edge's own updates
    always @(posedge aclk)
        if (core_stall === 1'b1)
            stall_n++;

    fdm_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .dev_reset(dev_reset),
        .core_stall(core_stall), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(s_rdata), .s_axi_rresp(rresp));
    fdm_core_model u_core (.aclk(aclk), .aresetn(aresetn), .go(go), .we(we),
        .addr(addr), .data(data), .done(done), .rdata(rdata), .resp(resp),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .s_rdata(s_rdata), .rresp(rresp));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one transfer; a hang is left to the watchdog, the answer time is checked
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v,
            input logic [1:0] er);
        int t;
        t = 0;
        go <= 1'b1;
        we <= w;
        addr <= a;
        data <= v;
        @(posedge aclk);
        go <= 1'b0;
        while (done !== 1'b1) begin
            @(posedge aclk);
            t++;
        end
        chk(32'(t < 400), 32'h1);
        chk({30'h0, resp}, {30'h0, er});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        bus(1'b1, a, v, fdm_pkg::RESP_OKAY);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00, fdm_pkg::RESP_OKAY);
        chk(rdata, exp);
    endtask
    task automatic ctl_chk(input logic [31:0] mask, input logic [31:0] exp);
        bus(1'b0, fdm_pkg::OFS_CONTROL, 8'h00, fdm_pkg::RESP_OKAY);
        chk(rdata & mask, exp);
    endtask
    function automatic logic [31:0] byte_exp(input logic [5:0] l);
        return {24'h0, mem[l]};
    endfunction
    // full unlock sequence, timed by the stall counter
    task automatic cycle(input logic [5:0] l, input logic [7:0] v, input logic erase);
        wr(fdm_pkg::OFS_LOCATION, {2'b00, l});
        wr(erase ? fdm_pkg::OFS_BITSET : fdm_pkg::OFS_BYTE, erase ? 8'h10 : v);
        wr(fdm_pkg::OFS_BITSET, 8'h04);
        stall_n = 0;
        wr(fdm_pkg::OFS_BITSET, 8'h02);
        chk(stall_n, 32'(fdm_pkg::BUSY_CYCLES));
    endtask
    task automatic fetch(input logic [5:0] l);
        wr(fdm_pkg::OFS_LOCATION, {2'b00, l});
        wr(fdm_pkg::OFS_BITSET, 8'h01);
        rd(fdm_pkg::OFS_BYTE, byte_exp(l));
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog: the whole sequence needs under two thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        complete_run;
    end

    initial begin
        foreach (mem[i])
            mem[i] = fdm_pkg::ERASED_BYTE;
        void'($urandom(32'h4a7b));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(fdm_pkg::OFS_CONTROL, 32'h0);
        rd(fdm_pkg::OFS_BYTE, {24'h0, fdm_pkg::BYTE_RESET});
        wr(fdm_pkg::OFS_LOCATION, 8'hff);
        rd(fdm_pkg::OFS_LOCATION, 32'h3f);
        wr(fdm_pkg::OFS_BYTE, 8'h5a);
        rd(fdm_pkg::OFS_BYTE, 32'h5a);
        bus(1'b0, 8'h10, 8'h00, fdm_pkg::RESP_SLVERR);
        chk(rdata, 32'h0);
        bus(1'b1, 8'h10, 8'h33, fdm_pkg::RESP_SLVERR);
        $display("test registers done");
        // write, read back, then erase the row through another address in it
        for (int k = 0; k < 4; k++) begin
            loc = (k == 0) ? 6'h3f : 6'($urandom);
            d = 8'($urandom);
            cycle(loc, d, 1'b0);
            mem[loc] = d;
            fetch(loc);
            ctl_chk(32'h12, 32'h0);
            wr(fdm_pkg::OFS_LOCATION, {2'b00, loc ^ 6'h08});
            rd(fdm_pkg::OFS_BYTE, {24'h0, d});
            cycle(loc ^ 6'h05, 8'h00, 1'b1); // erase before any rewrite
            for (int j = 0; j < 8; j++)
                mem[{loc[5:3], 3'(j)}] = fdm_pkg::ERASED_BYTE;
            ctl_chk(32'h12, 32'h0);
            fetch(loc);
        end
        $display("test write erase done");
        // broken or wrongly formed unlock sequences start nothing
        wr(fdm_pkg::OFS_CONTROL, 8'h00);
        stall_n = 0;
        wr(fdm_pkg::OFS_BITSET, 8'h10);
        wr(fdm_pkg::OFS_BYTE, 8'h77);
        ctl_chk(32'h10, 32'h0);
        wr(fdm_pkg::OFS_BITSET, 8'h04);
        wr(fdm_pkg::OFS_LOCATION, 8'h00);
        wr(fdm_pkg::OFS_BITSET, 8'h02);
        wr(fdm_pkg::OFS_CONTROL, 8'h04);
        wr(fdm_pkg::OFS_BITSET, 8'h02);
        wr(fdm_pkg::OFS_BITSET, 8'h06);
        chk(stall_n, 32'h0);
        ctl_chk(32'h06, 32'h0);
        fetch(6'h00);
        $display("test unlock done");
        // device reset cuts a write short
        wr(fdm_pkg::OFS_LOCATION, 8'h21);
        wr(fdm_pkg::OFS_BYTE, 8'h3c);
        wr(fdm_pkg::OFS_BITSET, 8'h04);
        fork
            wr(fdm_pkg::OFS_BITSET, 8'h02);
            begin
                repeat (30) @(posedge aclk);
                dev_reset <= 1'b1;
                @(posedge aclk);
                dev_reset <= 1'b0;
            end
        join
        ctl_chk(32'h0a, 32'h08);
        fetch(6'h21);
        cycle(6'h21, 8'hc3, 1'b0);
        mem[6'h21] = 8'hc3;
        ctl_chk(32'h08, 32'h0);
        fetch(6'h21);
        $display("test abort done");
        complete_run;
    end
endmodule
`default_nettype wire
